/* hw/fbr_defines.svh */
// field positions, opcodes, register addresses and reset values of the flash read front end
`ifndef FBR_DEFINES_SVH
`define FBR_DEFINES_SVH
`define FBR_ARRAY_AW 16
`define FBR_BOOT_EN_BIT 0
`define FBR_BOOT_DLY_MSB 8
`define FBR_BOOT_DLY_LSB 1
`define FBR_BOOT_PAGE_MSB 31
`define FBR_BOOT_PAGE_LSB 9
`define FBR_CFG1_LAT_MSB 7
`define FBR_CFG1_LAT_LSB 4
`define FBR_CFG1_WRAP_BIT 0
`define FBR_CFG2_LAT_MSB 3
`define FBR_CFG2_LAT_LSB 0
`define FBR_CFG3_LAT_MSB 7
`define FBR_CFG3_LAT_LSB 6
`define FBR_WRAP_LOG2 5
`define FBR_INFO_RG_MSB 9
`define FBR_INFO_RG_LSB 8
`define FBR_CMD_BITS 8'h08
`define FBR_PARAM_BYTES 16
`define FBR_OP_PLAIN_4B 8'h01
`define FBR_OP_PLAIN_ALT 8'h02
`define FBR_OP_FAST 8'h04
`define FBR_OP_IDENT 8'h08
`define FBR_OP_UNIQUE 8'h09
`define FBR_OP_PARAM 8'h0a
`define FBR_OP_GENREG 8'h10
`define FBR_OP_OCT_ARRAY 8'h20
`define FBR_OP_OCT_IDSPACE 8'h21
`define FBR_OP_OCT_BOOTCFG 8'h22
`define FBR_RA_CFG1 8'h01
`define FBR_RA_CFG2 8'h02
`define FBR_RA_CFG3 8'h03
`define FBR_RA_BOOT0 8'h10
`define FBR_RA_BOOT1 8'h11
`define FBR_RA_BOOT2 8'h12
`define FBR_RA_BOOT3 8'h13
`define FBR_SEL_BOOT 2'h0
`define FBR_SEL_CFG1 2'h1
`define FBR_SEL_CFG2 2'h2
`define FBR_SEL_CFG3 2'h3
`define FBR_BOOT_CFG_RST 32'h0000_0000
`define FBR_CFGX_RST 8'h00
`endif

/* hw/fbr_pkg.sv */
// shared types of the flash read front end
package fbr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_ADDR = 3'b010,
        ST_LAT = 3'b011,
        ST_DATA = 3'b100,
        ST_HOLD = 3'b101
    } fbr_state_t;
    typedef enum logic [1:0] {
        SRC_ARRAY = 2'b00,
        SRC_INFO = 2'b01,
        SRC_REG = 2'b10,
        SRC_BOOTCFG = 2'b11
    } fbr_src_t;
    typedef enum logic [1:0] {
        RG_IDENT = 2'b00,
        RG_UNIQUE = 2'b01,
        RG_PARAM = 2'b10,
        RG_NONE = 2'b11
    } fbr_region_t;
    typedef struct packed {
        logic [31:0] boot;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] c3;
        logic octal;
        logic pw_enabled;
        logic pw_supplied;
    } fbr_cfg_t;
endpackage

/* hw/fbr_sync.sv */
// three-flop level synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module fbr_sync
    import fbr_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // s1 feeds s2 only; the output moves when the later stages match
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q <= '0;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                q <= s3;
        end
    end
endmodule // fbr_sync

/* hw/fbr_info_rom.sv */
// identification, unique identifier and parameter space bytes
`timescale 1ns/10ps
`include "fbr_defines.svh"
module fbr_info_rom
    import fbr_pkg::*;
#(
    parameter logic [31:0] ID_CODE = 32'h5a5a_0101, // arbitrary value
    parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // arbitrary value
)
(
    input wire fbr_region_t region,
    input wire logic [7:0] idx,
    output logic [7:0] data
);
    // arbitrary contents; real parts load these at the factory
    localparam logic [7:0] PTAB [`FBR_PARAM_BYTES] = '{
        8'h10, 8'h21, 8'h32, 8'h43, 8'h54, 8'h65, 8'h76, 8'h87,
        8'h98, 8'ha9, 8'hba, 8'hcb, 8'hdc, 8'hed, 8'hfe, 8'h0f};

    logic [7:0] id_byte;
    logic [7:0] uid_byte;
    logic [7:0] par_byte;

    // most significant byte first, ident repeating every four bytes, unique value every eight
    assign id_byte = ID_CODE[8*(3-idx[1:0]) +: 8];
    assign uid_byte = UNIQUE_ID[8*(7-idx[2:0]) +: 8];
    // beyond the table the space reads as erased
    assign par_byte = (idx < 8'(`FBR_PARAM_BYTES)) ? PTAB[idx[3:0]] : 8'hff;

    // region selection
    assign data = (region == RG_IDENT) ? id_byte :
                  (region == RG_UNIQUE) ? uid_byte :
                  (region == RG_PARAM) ? par_byte : 8'hff;
endmodule // fbr_info_rom

/* hw/fbr_read_front.sv */
// read front end of a serial flash: boot read, array, ident, parameter and register reads
`timescale 1ns/10ps
// Functional notes
// R1 - with boot read enabled, first frame after reset streams data without command
// R2 - boot start address is page field bits 31:9 times 512
// R3 - wait the delay field bits 8:1 in clocks before boot data
// R4 - host programs delay long enough for array access at its clock
// R5 - boot read suppressed while read password protection is enabled
// R6 - host keeps wrapping off when boot read is used
// R7 - with interface check enabled host clocks at least four words
// R8 - host reads status register one after every boot read
// R9 - reads insert latency after command and address, except plain reads
// R10 - octal link drives a strobe toggling with each data byte
// R11 - ident read: no address in SPI; latency from config three or one
// R12 - SPI parameter read takes three address bytes, random start
// R13 - parameter read refused while password required but not given
// R14 - unique ident read behaves like ident read, returns 64-bit value
// R15 - array read starts anywhere and increments until chip select high
// R16 - sequential read past top address continues at zero
// R17 - octal array read: strobe, linear or wrapped, latency config one
// R18 - plain SPI read has no latency and no strobe
// R19 - SPI fast read latency from config two bits 3:0
// R20 - generic register read on SPI only; dedicated reads on both; code has its one dedicated read (boot config) on octal only
// R21 - boot read continues sequentially like a normal array read
`include "fbr_defines.svh"
module fbr_read_front
    import fbr_pkg::*;
#(
    parameter int AW = `FBR_ARRAY_AW,
    parameter logic [31:0] BOOT_CFG_INIT = `FBR_BOOT_CFG_RST
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_sel,
    input wire logic [31:0] cfg_wdata,
    input wire logic link_octal,
    input wire logic pw_enabled,
    input wire logic pw_supplied,
    output logic cfg_busy,
    output logic boot_pending,
    input wire logic lclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe,
    output logic ds,
    output logic ds_oe,
    output logic [AW-1:0] arr_addr,
    input wire logic [7:0] arr_rdata
);
    // page alignment and wrap window need room in the address
    if (AW < `FBR_BOOT_PAGE_LSB + 1 || AW > 32)
    begin : g_bad_aw
        $error("array address width out of range");
    end

    localparam fbr_cfg_t CFG_RST = '{boot: BOOT_CFG_INIT, c1: `FBR_CFGX_RST,
        c2: `FBR_CFGX_RST, c3: `FBR_CFGX_RST, octal: 1'b0, pw_enabled: 1'b0,
        pw_supplied: 1'b0};

    fbr_cfg_t cfg_m;
    fbr_cfg_t cfg_l;
    logic req_tgl, send_pend, arm_init, boot_arm;
    logic ack_tgl, boot_taken;
    logic ack_s, taken_s, req_s, arm_s, lrst;
    logic hs_busy, wr_ok, lvl_chg;

    // configuration crossing: words stay still until the link side acknowledges
    assign hs_busy = req_tgl != ack_s;
    assign wr_ok = cfg_wr && !hs_busy;
    assign lvl_chg = (pw_enabled != cfg_m.pw_enabled) || (pw_supplied != cfg_m.pw_supplied)
                     || (link_octal != cfg_m.octal);

    fbr_sync #(.W(1)) u_ack_sync (.clk(mclk), .rst(srst), .d(ack_tgl), .q(ack_s));
    fbr_sync #(.W(1)) u_take_sync (.clk(mclk), .rst(srst), .d(boot_taken), .q(taken_s));
    fbr_sync #(.W(1)) u_rst_sync (.clk(lclk), .rst(1'b0), .d(srst), .q(lrst));
    fbr_sync #(.W(1)) u_req_sync (.clk(lclk), .rst(lrst), .d(req_tgl), .q(req_s));
    fbr_sync #(.W(1)) u_arm_sync (.clk(lclk), .rst(lrst), .d(boot_arm), .q(arm_s));

    // system side register store; writes during a pending transfer are dropped
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cfg_m <= CFG_RST;
            req_tgl <= 1'b0;
            send_pend <= 1'b1;
            cfg_busy <= 1'b0;
        end
        else
        begin
            if (wr_ok)
            begin
                case (cfg_sel)
                    `FBR_SEL_BOOT: cfg_m.boot <= cfg_wdata;
                    `FBR_SEL_CFG1: cfg_m.c1 <= cfg_wdata[7:0];
                    `FBR_SEL_CFG2: cfg_m.c2 <= cfg_wdata[7:0];
                    `FBR_SEL_CFG3: cfg_m.c3 <= cfg_wdata[7:0];
                    default: cfg_m.c1 <= cfg_m.c1;
                endcase
            end
            if (lvl_chg && !hs_busy)
            begin
                cfg_m.pw_enabled <= pw_enabled;
                cfg_m.pw_supplied <= pw_supplied;
                cfg_m.octal <= link_octal;
            end
            if (!hs_busy && (send_pend || cfg_wr || lvl_chg))
            begin
                req_tgl <= ~req_tgl;
                send_pend <= 1'b0;
            end
            cfg_busy <= hs_busy;
        end
    end

    // boot arming once per reset, released when the link has started it
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            arm_init <= 1'b1;
            boot_arm <= 1'b0;
            boot_pending <= 1'b0;
        end
        else
        begin
            if (arm_init)
            begin
                // R5 password blocks boot
                boot_arm <= cfg_m.boot[`FBR_BOOT_EN_BIT] && !pw_enabled;
                arm_init <= 1'b0;
            end
            else if (taken_s)
                boot_arm <= 1'b0;
            boot_pending <= boot_arm;
        end
    end

    fbr_state_t st;
    fbr_src_t src;
    fbr_region_t region;
    logic [7:0] cnt, cmd, lat_q, regsel, idx, out_sh;
    logic [31:0] sh;
    logic [2:0] bitc;
    logic [AW-1:0] addr;
    logic wrap_on, oct, lock, boot_go, cmd_last, addr_last, load;
    logic [7:0] cmd_in, boot_dly, info_byte, reg_byte, boot_byte, src_byte;
    logic [31:0] addr_full, boot_base;
    logic [AW-1:0] boot_start, addr_next, arr_inc;
    fbr_region_t eff_region;

    // link side shadow of the configuration and boot handshake
    always_ff @(posedge lclk)
    begin
        if (lrst)
        begin
            cfg_l <= CFG_RST;
            ack_tgl <= 1'b0;
            boot_taken <= 1'b0;
        end
        else
        begin
            if (req_s != ack_tgl)
            begin
                cfg_l <= cfg_m;
                ack_tgl <= req_s;
            end
            if (boot_go)
                boot_taken <= 1'b1;
            else if (!arm_s)
                boot_taken <= 1'b0;
        end
    end

    // link decode
    assign oct = cfg_l.octal;
    assign lock = cfg_l.pw_enabled && !cfg_l.pw_supplied;
    assign cmd_in = oct ? dq_in : {cmd[6:0], si};
    assign cmd_last = oct || (cnt == 8'h01);
    assign addr_last = cnt == 8'h01;
    assign addr_full = oct ? {sh[23:0], dq_in} : {sh[30:0], si};
    assign eff_region = (oct && src == SRC_INFO) ?
        fbr_region_t'(addr_full[`FBR_INFO_RG_MSB:`FBR_INFO_RG_LSB]) : region;
    // R2 page aligned start
    assign boot_base = {cfg_l.boot[`FBR_BOOT_PAGE_MSB:`FBR_BOOT_PAGE_LSB],
                        {`FBR_BOOT_PAGE_LSB{1'b0}}};
    assign boot_start = boot_base[AW-1:0];
    assign boot_dly = cfg_l.boot[`FBR_BOOT_DLY_MSB:`FBR_BOOT_DLY_LSB];
    // R1 boot on first edge of first frame
    assign boot_go = (st == ST_IDLE) && !cs_n && !lrst && arm_s && !boot_taken
                     && cfg_l.boot[`FBR_BOOT_EN_BIT] && !cfg_l.pw_enabled;
    assign load = oct || (bitc == 3'h0);
    assign arr_inc = arr_addr + 1'b1;

    // R16 natural roll-over to zero; wrap keeps the aligned window
    assign addr_next = wrap_on ?
        {addr[AW-1:`FBR_WRAP_LOG2], addr[`FBR_WRAP_LOG2-1:0] + 1'b1} : addr + 1'b1;

    logic d_ok;
    logic [2:0] d_nb;
    logic [7:0] d_lat;
    fbr_src_t d_src;
    fbr_region_t d_rg;
    // command table; unknown or foreign-link opcodes are ignored for the frame
    always_comb
    begin
        d_ok = 1'b1;
        d_nb = 3'h0;
        d_lat = 8'h00;
        d_src = SRC_INFO;
        d_rg = RG_NONE;
        case ({oct, cmd_in})
            // R18 plain reads, no latency
            {1'b0, `FBR_OP_PLAIN_4B}: begin d_nb = 3'h4; d_src = SRC_ARRAY; end
            {1'b0, `FBR_OP_PLAIN_ALT}: begin d_nb = 3'h3; d_src = SRC_ARRAY; end
            // R19 fast read latency
            {1'b0, `FBR_OP_FAST}:
            begin
                d_nb = 3'h3;
                d_src = SRC_ARRAY;
                d_lat = {4'h0, cfg_l.c2[`FBR_CFG2_LAT_MSB:`FBR_CFG2_LAT_LSB]};
            end
            // R11 ident without address
            {1'b0, `FBR_OP_IDENT}:
            begin
                d_rg = RG_IDENT;
                d_lat = {6'h00, cfg_l.c3[`FBR_CFG3_LAT_MSB:`FBR_CFG3_LAT_LSB]};
            end
            // R14 unique value, same framing
            {1'b0, `FBR_OP_UNIQUE}:
            begin
                d_rg = RG_UNIQUE;
                d_lat = {6'h00, cfg_l.c3[`FBR_CFG3_LAT_MSB:`FBR_CFG3_LAT_LSB]};
            end
            // R12 three address bytes
            {1'b0, `FBR_OP_PARAM}:
            begin
                d_nb = 3'h3;
                d_rg = RG_PARAM;
                d_lat = {6'h00, cfg_l.c3[`FBR_CFG3_LAT_MSB:`FBR_CFG3_LAT_LSB]};
            end
            // R20 generic read on SPI only
            {1'b0, `FBR_OP_GENREG}:
            begin
                d_nb = 3'h4;
                d_src = SRC_REG;
                d_lat = {6'h00, cfg_l.c3[`FBR_CFG3_LAT_MSB:`FBR_CFG3_LAT_LSB]};
            end
            // R17 octal array read
            {1'b1, `FBR_OP_OCT_ARRAY}:
            begin
                d_nb = 3'h4;
                d_src = SRC_ARRAY;
                d_lat = {4'h0, cfg_l.c1[`FBR_CFG1_LAT_MSB:`FBR_CFG1_LAT_LSB]};
            end
            {1'b1, `FBR_OP_OCT_IDSPACE}:
            begin
                d_nb = 3'h4;
                d_lat = {4'h0, cfg_l.c1[`FBR_CFG1_LAT_MSB:`FBR_CFG1_LAT_LSB]};
            end
            {1'b1, `FBR_OP_OCT_BOOTCFG}:
            begin
                d_src = SRC_BOOTCFG;
                d_lat = {4'h0, cfg_l.c1[`FBR_CFG1_LAT_MSB:`FBR_CFG1_LAT_LSB]};
            end
            default: d_ok = 1'b0;
        endcase
    end

    fbr_info_rom u_info (.region(region), .idx(idx), .data(info_byte));

    // register byte select, undefined addresses read as zero
    assign reg_byte = (regsel == `FBR_RA_CFG1) ? cfg_l.c1 :
                      (regsel == `FBR_RA_CFG2) ? cfg_l.c2 :
                      (regsel == `FBR_RA_CFG3) ? cfg_l.c3 :
                      (regsel == `FBR_RA_BOOT0) ? cfg_l.boot[7:0] :
                      (regsel == `FBR_RA_BOOT1) ? cfg_l.boot[15:8] :
                      (regsel == `FBR_RA_BOOT2) ? cfg_l.boot[23:16] :
                      (regsel == `FBR_RA_BOOT3) ? cfg_l.boot[31:24] : 8'h00;
    assign boot_byte = cfg_l.boot[8*(3-idx[1:0]) +: 8];
    assign src_byte = (src == SRC_ARRAY) ? arr_rdata :
                      (src == SRC_INFO) ? info_byte :
                      (src == SRC_REG) ? reg_byte : boot_byte;

    // frame engine; chip select high ends the frame with no clock edge needed
    always_ff @(posedge lclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            st <= ST_IDLE;
            cnt <= `FBR_CMD_BITS;
            cmd <= 8'h00;
            sh <= 32'h0000_0000;
            lat_q <= 8'h00;
            src <= SRC_ARRAY;
            region <= RG_NONE;
            regsel <= 8'h00;
            idx <= 8'h00;
            addr <= '0;
            wrap_on <= 1'b0;
            bitc <= 3'h0;
            out_sh <= 8'h00;
            so <= 1'b0;
            so_oe <= 1'b0;
            dq_out <= 8'h00;
            dq_oe <= 1'b0;
            ds <= 1'b0;
            ds_oe <= 1'b0;
            arr_addr <= '0;
        end
        else if (!lrst)
        begin
            case (st)
                ST_IDLE, ST_CMD:
                begin
                    if (boot_go)
                    begin
                        // R3 delay then data; R6 boot stream always linear
                        // R21 sequential from the start page
                        arr_addr <= boot_start;
                        addr <= boot_start + 1'b1;
                        src <= SRC_ARRAY;
                        ds_oe <= oct;
                        cnt <= boot_dly;
                        st <= (boot_dly == 8'h00) ? ST_DATA : ST_LAT;
                    end
                    else if (cmd_last)
                    begin
                        src <= d_src;
                        region <= d_rg;
                        lat_q <= d_lat;
                        wrap_on <= oct && cfg_l.c1[`FBR_CFG1_WRAP_BIT];
                        ds_oe <= oct && d_ok;
                        if (!d_ok)
                            st <= ST_HOLD;
                        else if (d_nb != 3'h0)
                        begin
                            st <= ST_ADDR;
                            cnt <= oct ? {5'h00, d_nb} : {2'b00, d_nb, 3'b000};
                        end
                        else
                        begin
                            // R9 latency before data
                            cnt <= d_lat;
                            st <= (d_lat == 8'h00) ? ST_DATA : ST_LAT;
                        end
                    end
                    else
                    begin
                        cmd <= cmd_in;
                        cnt <= cnt - 8'h01;
                        st <= ST_CMD;
                    end
                end
                ST_ADDR:
                begin
                    sh <= addr_full;
                    cnt <= cnt - 8'h01;
                    if (addr_last)
                    begin
                        // R15 any byte start; R12 random start in parameter space
                        arr_addr <= addr_full[AW-1:0];
                        addr <= addr_full[AW-1:0] + 1'b1;
                        idx <= addr_full[7:0];
                        regsel <= addr_full[7:0];
                        region <= eff_region;
                        cnt <= lat_q;
                        // R13 parameter space locked by password
                        if (src == SRC_INFO && eff_region == RG_PARAM && lock)
                            st <= ST_HOLD;
                        else
                            st <= (lat_q == 8'h00) ? ST_DATA : ST_LAT;
                    end
                end
                ST_LAT:
                begin
                    // R9 count latency cycles
                    cnt <= cnt - 8'h01;
                    if (cnt == 8'h01)
                        st <= ST_DATA;
                end
                ST_DATA:
                begin
                    bitc <= bitc + 3'h1;
                    so_oe <= !oct;
                    dq_oe <= oct;
                    if (load)
                    begin
                        // R15 next byte address fetched ahead
                        arr_addr <= addr;
                        addr <= addr_next;
                        idx <= idx + 8'h01;
                        so <= src_byte[7];
                        out_sh <= {src_byte[6:0], 1'b0};
                        dq_out <= src_byte;
                        // R10 strobe edge per byte
                        ds <= oct ? ~ds : 1'b0;
                    end
                    else
                    begin
                        so <= out_sh[7];
                        out_sh <= {out_sh[6:0], 1'b0};
                    end
                end
                default: st <= ST_HOLD;
            endcase
        end
    end

    default clocking cb @(posedge lclk); endclocking
    default disable iff (lrst || cs_n);

    AST_BOOT_START: assert property (boot_go |=> arr_addr == $past(boot_start)) // R2
        else $error("boot read did not start at the page address");
    AST_BOOT_WAIT: assert property ((boot_go && boot_dly > 8'h01) |=> // R3
        (st == ST_LAT && cnt == $past(boot_dly) && !so_oe && !dq_oe))
        else $error("boot delay not honoured");
    AST_BOOT_PW: assert property (@(posedge mclk) disable iff (srst) // R5
        (arm_init && pw_enabled) |=> !boot_arm)
        else $error("boot read armed under password protection");
    AST_LAT_COUNT: assert property ((st == ST_LAT && cnt > 8'h01) |=> // R9
        (st == ST_LAT && cnt == $past(cnt) - 8'h01 && !so_oe && !dq_oe))
        else $error("latency count broken");
    AST_DS_TOGGLE: assert property ((st == ST_DATA && oct) |=> // R10
        (ds != $past(ds) && ds_oe && dq_oe))
        else $error("strobe did not follow octal data");
    AST_DS_SPI: assert property (!oct |-> !ds_oe) // R18
        else $error("strobe driven on the single-bit link");
    AST_IDENT_NOADDR: assert property ((st == ST_CMD && !oct && cmd_last // R11
        && cmd_in == `FBR_OP_IDENT) |=> st != ST_ADDR)
        else $error("ident read took address cycles");
    AST_PARAM_REFUSE: assert property (st == ST_HOLD |-> (!so_oe && !dq_oe) [*2]) // R13
        else $error("refused read drove data");
    AST_ARRAY_SEQ: assert property ((st == ST_DATA && oct && src == SRC_ARRAY // R16
        && !wrap_on) ##1 st == ST_DATA |-> arr_addr == $past(arr_inc))
        else $error("array address did not step or roll over");
    AST_NOLAT_START: assert property ((st == ST_ADDR && addr_last && lat_q == 8'h00 // R18
        && !(src == SRC_INFO && eff_region == RG_PARAM && lock)) |=> st == ST_DATA ##1
        (so_oe || dq_oe))
        else $error("zero latency read did not start data");

    COV_BOOT: cover property (boot_go ##[1:300] st == ST_DATA);
    COV_FAST: cover property (st == ST_LAT && !oct ##[1:20] so_oe);
    COV_OCT: cover property (st == ST_DATA && oct [*4]);
    COV_REFUSE: cover property (st == ST_ADDR ##1 st == ST_HOLD);
endmodule // fbr_read_front

/* verif/fbr_host.sv */
// host side model: link clock, chip select and serial command bits
`timescale 1ns/10ps
module fbr_host
(
    output logic lclk,
    output logic cs_n,
    output logic si
);
    // half period, widened for plain reads
    int hp = 6;
    initial
    begin
        lclk = 0;
        cs_n = 1;
        si = 0;
    end
    // clock only runs inside tasks, standing still between frames
    task automatic pulse(input int n);
        repeat (n)
        begin
            #(hp) lclk = 1;
            #(hp) lclk = 0;
        end
    endtask
    // header msb first, then latency and data clocks
    task automatic frame(input logic [39:0] hdr, input int nh, input int nd);
        cs_n = 0;
        for (int i = 0; i < nh; i++)
        begin
            si = hdr[nh-1-i];
            pulse(1);
        end
        si = ~si; // released line must not keep its value
        pulse(nd);
        #1 cs_n = 1;
        pulse(2);
    endtask
endmodule // fbr_host

/* verif/flash_boot_read_and_read_transactions_tb_top.sv */
// self-checking bench of the flash read front end
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t mismatch", $time); end end
module flash_boot_read_and_read_transactions_tb_top;
    import fbr_pkg::*;
    logic mclk = 0, srst = 1, cfg_wr = 0, link_octal = 0, pw_enabled = 0, pw_supplied = 0;
    logic [1:0] cfg_sel = 2'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic [7:0] dq_in = 8'h00;
    logic cfg_busy, boot_pending, lclk, cs_n, si, so, so_oe, dq_oe, ds, ds_oe;
    logic [7:0] dq_out, sh, arr_rdata;
    logic [15:0] arr_addr, a;
    logic [3:0] l2;
    logic pds = 1'b0;
    localparam logic [31:0] BOOT = {23'h1, 8'h03, 1'b1};
    int errors = 0, checks_done = 0, nb = 0, cyc = 0;
    logic [7:0] exp_q[$];
    // array pattern, neighbours and the two ends differ
    function automatic logic [7:0] mem(input logic [15:0] x);
        return x[7:0] + 8'h03 * x[15:8] + 8'h17;
    endfunction
    assign arr_rdata = mem(arr_addr);
    always #12.5 mclk = ~mclk;
    // page 1, delay 3, wrap left off
    fbr_read_front #(.AW(16), .BOOT_CFG_INIT(BOOT)) fbr_read_front_i (.mclk,
        .srst, .cfg_wr, .cfg_sel, .cfg_wdata, .link_octal, .pw_enabled, .pw_supplied,
        .cfg_busy, .boot_pending, .lclk, .cs_n, .si, .so, .so_oe, .dq_in, .dq_out, .dq_oe,
        .ds, .ds_oe, .arr_addr, .arr_rdata);
    fbr_host fbr_host_i (.lclk, .cs_n, .si);
    task automatic results;
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // cut a hang short
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            errors++;
            results;
        end
    end
    // gather octal and serial bytes, settled at the falling edge
    always @(negedge lclk)
    begin
        if (cs_n)
        begin
            nb = 0;
            pds = 1'b0;
        end
        else if (dq_oe === 1'b1)
        begin
            `CHK(ds_oe, 1'b1)
            `CHK(ds, ~pds)
            pds = ds;
            if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
            else `CHK(dq_out, exp_q.pop_front())
        end
        else if (so_oe === 1'b1)
        begin
            sh = {sh[6:0], so};
            nb++;
            if (nb == 8)
            begin
                nb = 0;
                if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
                else `CHK(sh, exp_q.pop_front())
            end
        end
    end
    task automatic ex(input logic [15:0] s, input int n);
        for (int i = 0; i < n; i++)
            exp_q.push_back(mem(s + 16'(i)));
    endtask
    task automatic wcfg(input logic [1:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cfg_wr <= 1;
        cfg_sel <= s;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_wr <= 0;
        fbr_host_i.pulse(4);
        while (cfg_busy !== 1'b0 && n < 100)
        begin
            fbr_host_i.pulse(1);
            n++;
        end
        `CHK(cfg_busy, 1'b0)
        fbr_host_i.pulse(4);
    endtask
    initial
    begin
        void'($urandom(28));
        fork
            fbr_host_i.pulse(5);
            repeat (2) @(posedge mclk);
        join
        srst <= 0;
        fbr_host_i.pulse(40);
        `CHK(boot_pending, 1'b1)
        // boot frame, no command, four bytes from page 1
        ex(16'h0200, 4);
        fbr_host_i.frame(40'h0, 1, 3 + 32);
        fbr_host_i.pulse(20);
        `CHK(exp_q.size(), 0)
        `CHK(boot_pending, 1'b0)
        // host checks its boot setup through the generic register read
        exp_q.push_back(BOOT[7:0]);
        exp_q.push_back(BOOT[7:0]);
        fbr_host_i.frame({8'h10, 32'h0000_0010}, 40, 16);
        `CHK(exp_q.size(), 0)
        // fast read at the top address with random latency
        l2 = 4'($urandom % 16);
        wcfg(2'h2, {28'h0, l2});
        ex(16'hffff, 2);
        fbr_host_i.frame({8'h00, 8'h04, 8'h00, 16'hffff}, 32, int'(l2) + 16);
        `CHK(exp_q.size(), 0)
        // both plain reads, zero latency at 50 MHz
        fbr_host_i.hp = 10;
        for (int k = 0; k < 2; k++)
        begin
            a = 16'($urandom);
            ex(a, 3);
            fbr_host_i.frame(k ? {8'h00, 8'h02, 8'h00, a} : {8'h01, 16'h0, a}, k ? 32 : 40, 24);
            `CHK(exp_q.size(), 0)
        end
        fbr_host_i.hp = 6;
        // parameter read refused while password missing
        pw_enabled <= 1;
        fbr_host_i.pulse(30);
        fbr_host_i.frame({8'h00, 8'h0a, 24'h000004}, 32, 40);
        // password given; past the table the space reads erased
        @(posedge mclk);
        pw_supplied <= 1;
        fbr_host_i.pulse(30);
        exp_q.push_back(8'hff);
        exp_q.push_back(8'hff);
        fbr_host_i.frame({8'h00, 8'h0a, 24'h000020}, 32, 16);
        `CHK(exp_q.size(), 0)
        // second reset under password protection, octal link afterwards
        @(posedge mclk);
        srst <= 1;
        link_octal <= 1;
        dq_in <= 8'h22;
        fork
            fbr_host_i.pulse(5);
            repeat (2) @(posedge mclk);
        join
        @(posedge mclk);
        srst <= 0;
        fbr_host_i.pulse(40);
        `CHK(boot_pending, 1'b0)
        // dedicated boot register read, four bytes repeated
        repeat (2)
            for (int i = 3; i >= 0; i--)
                exp_q.push_back(BOOT[8*i +: 8]);
        fbr_host_i.frame(40'h0, 1, 8);
        `CHK(exp_q.size(), 0)
        // a random non-opcode on the octal link gives no data
        @(posedge mclk);
        dq_in <= {1'b1, 7'($urandom)};
        fbr_host_i.frame(40'h0, 1, 8);
        results;
    end
endmodule // flash_boot_read_and_read_transactions_tb_top
